// >>> src/dsc_cfg.svh
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
// ----------------------------------------
// port map, low address byte only
// ----------------------------------------
`define DSC_ADDR_CHA_CTRL 8'hE0
`define DSC_ADDR_CHA_DATA 8'hE1
`define DSC_ADDR_CHB_CTRL 8'hE2
`define DSC_ADDR_CHB_DATA 8'hE3
`define DSC_ADDR_BLK_MASK 8'hFC
// ----------------------------------------
// register pointer values
// ----------------------------------------
`define DSC_PTR_CMD 4'h0
`define DSC_PTR_SRX 4'h1
`define DSC_PTR_VEC 4'h2
`define DSC_PTR_RXP 4'h3
`define DSC_PTR_MMODE 4'h4
`define DSC_PTR_TXP 4'h5
`define DSC_PTR_FCNT_LO 4'h6
`define DSC_PTR_SYNC 4'h7
`define DSC_PTR_DATA 4'h8
`define DSC_PTR_MIC 4'h9
`define DSC_PTR_MCTL 4'hA
`define DSC_PTR_RB_MCTL 4'hB
`define DSC_PTR_RB_SYNC 4'hE
`define DSC_PTR_ESC 4'hF
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define DSC_CMD_POINT_HIGH 3'h1
`define DSC_EXT_CRC32_BIT 7
`define DSC_EXT_READBACK_BIT 6
`define DSC_ESC_EXT_EN_BIT 0
`define DSC_ESC_FIFO_EN_BIT 2
`define DSC_SRX_CRC_BIT 6
`define DSC_MIC_STAT_HIGH_BIT 4
`define DSC_MCTL_PRESET_BIT 7
`define DSC_REG_RST 8'h00
`define DSC_VEC_NONE 3'h3
// ----------------------------------------
// crc polynomials and good-frame residues
// ----------------------------------------
`define DSC_POLY32 32'h04C11DB7
`define DSC_POLY16 16'h1021
`define DSC_RES32 32'hC704DD7B
`define DSC_RES16 16'h1D0F
// ----------------------------------------
// frame status fifo
// ----------------------------------------
`define DSC_FIFO_DEPTH 10
`define DSC_FIFO_W 19
`define DSC_CNT_W 14
`endif

// >>> src/dsc_host_access.sv
`timescale 1ns/1ps
`include "dsc_cfg.svh"
// Operation
// - only low eight address bits decoded; ports repeat in every I/O page.
// - channel A control E0h, data E1h; channel B control E2h, data E3h.
// - emulation interface enabled disconnects channel B from its output pins.
// - channel B transmit/receive clock feeds the emulation timers.
// - data port access reaches data register directly, no pointer write.
// - first control write is command/pointer, three bits select target register.
// - pointer clears after each indirect read or write completes.
// - transmitter generates and receiver checks 32-bit ethernet crc.
// - extended feature bit 7 selects 32-bit crc, overriding 16-bit.
// - with override, only 32-bit crc appended and compared.
// - 32-bit compare result shows in special receive status bit 6.
// - 32-bit compare result also stored in 10x19 frame status fifo.
// - crc generator still presettable to zeros or ones in 32-bit mode.
// - 32-bit crc mode disabled at power-up and reset.
// - never 16-bit and 32-bit crc at once; only selected width.
// - serial core clocked at system clock divided by 1 or 2.
// - after reset, divide-by-1 is used.
// - vector and master interrupt registers shared, reachable via both channels.
// - extended feature register writable only while status control D0 set.
// - vector read A unmodified, B status-modified; pending bits on A only.
// - frame fifo byte counts readable only while status control D2 set.
// - extended bit 6 makes five write registers readable at read-back slots.
module dsc_host_access #(
  parameter int FIFO_DEPTH = `DSC_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata_r,
  input wire logic [7:0] primary_status_a_in,
  input wire logic [7:0] primary_status_b_in,
  input wire logic [7:0] rx_data_a_in,
  input wire logic [7:0] rx_data_b_in,
  input wire logic [5:0] interrupt_pending_bits,
  input wire logic [1:0] crc_preset_in,
  input wire logic [1:0] crc_bit_valid_in,
  input wire logic [1:0] crc_bit_in,
  input wire logic [1:0] rx_byte_in,
  input wire logic [1:0] frame_end_in,
  input wire logic clk_div2_in,
  input wire logic emu_enable_in,
  input wire logic chan_b_txrx_clock_pin,
  input wire logic [3:0] chb_core_out_in,
  input wire logic [3:0] chb_core_oe_in,
  output logic [7:0] tx_data_r,
  output logic [1:0] tx_load_r,
  output logic [1:0] rx_take_r,
  output logic [1:0] crc_mode32_r,
  output logic [31:0] tx_crc_a_r,
  output logic [31:0] tx_crc_b_r,
  output logic [7:0] int_vector_r,
  output logic [7:0] master_int_ctrl_r,
  output logic scc_clk_en_r,
  output logic [3:0] chb_pin_out_r,
  output logic [3:0] chb_pin_oe_r,
  output logic emu_timer_clk_r
);
  localparam int PW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one serial crc step; 16-bit mode keeps the upper half at zero
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b, input logic w32);
    logic fb;
    fb = w32 ? (c[31] ^ b) : (c[15] ^ b);
    if (w32) begin
      crc_step = {c[30:0], 1'b0} ^ (fb ? `DSC_POLY32 : 32'h0000_0000);
    end else begin
      crc_step = {16'h0000, {c[14:0], 1'b0} ^ (fb ? `DSC_POLY16 : 16'h0000)};
    end
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] ptr_r [2];
  logic [7:0] wr3_r [2];
  logic [7:0] wr4_r [2];
  logic [7:0] wr5_r [2];
  logic [7:0] wr7_r [2];
  logic [7:0] wr7p_r [2];
  logic [7:0] misc_ctrl_write_reg_r [2];
  logic [7:0] ext_status_ctrl_write_reg_r [2];
  logic [31:0] crc_r [2];
  logic [1:0] crc_err_r;
  logic [13:0] bcnt_r [2];
  dsc_pkg::dsc_fifo_entry_t fifo_mem [2][FIFO_DEPTH];
  logic [PW-1:0] fwp_r [2];
  logic [PW-1:0] frp_r [2];
  logic [PW-1:0] fcnt_r [2];
  logic [1:0] fovf_r;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // upper address byte is ignored so the ports appear in every page
  wire [7:0] lo = io_addr[7:0];
  wire hit = ((lo & `DSC_ADDR_BLK_MASK) == `DSC_ADDR_CHA_CTRL);
  wire ch = lo[1];
  wire is_data = lo[0];
  wire wr = io_wr & hit;
  wire rd = io_rd & hit;
  wire [3:0] cur_ptr = ptr_r[ch];
  wire [3:0] idx = is_data ? `DSC_PTR_DATA : cur_ptr;
  wire cmd_wr = wr & ~is_data & (cur_ptr == `DSC_PTR_CMD);
  wire reg_wr = wr & ~cmd_wr;
  wire ctrl_done = (wr | rd) & ~is_data & ~cmd_wr;
  wire [3:0] cmd_ptr = {io_wdata[5:3] == `DSC_CMD_POINT_HIGH, io_wdata[2:0]};
  wire ext_sel = ext_status_ctrl_write_reg_r[ch][`DSC_ESC_EXT_EN_BIT];
  wire rb_en = wr7p_r[ch][`DSC_EXT_READBACK_BIT];
  wire fifo_en = ext_status_ctrl_write_reg_r[ch][`DSC_ESC_FIFO_EN_BIT];
  wire mic_wr = reg_wr & (idx == `DSC_PTR_MIC);
  dsc_pkg::dsc_rst_cmd_t rst_cmd;
  assign rst_cmd = dsc_pkg::dsc_rst_cmd_t'(io_wdata[7:6]);
  wire [1:0] ch_rst = {mic_wr & (rst_cmd == dsc_pkg::DSC_RST_CHB || rst_cmd == dsc_pkg::DSC_RST_HW),
                       mic_wr & (rst_cmd == dsc_pkg::DSC_RST_CHA || rst_cmd == dsc_pkg::DSC_RST_HW)};

  // ----------------------------------------
  // interrupt vector read
  // ----------------------------------------
  // highest pending source picks the status code; channel A receive first
  wire [5:0] ip = interrupt_pending_bits;
  wire [2:0] vcode = ip[5] ? 3'h6 : ip[4] ? 3'h4 : ip[3] ? 3'h5 :
                     ip[2] ? 3'h2 : ip[1] ? 3'h0 : ip[0] ? 3'h1 : `DSC_VEC_NONE;
  wire [7:0] vec_mod = master_int_ctrl_r[`DSC_MIC_STAT_HIGH_BIT] ?
                       {int_vector_r[7], vcode[0], vcode[1], vcode[2], int_vector_r[3:0]} :
                       {int_vector_r[7:4], vcode, int_vector_r[0]};

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  wire [PW-1:0] head = frp_r[ch];
  wire [18:0] fhead = fifo_mem[ch][head];
  wire fvalid = (fcnt_r[ch] != '0);
  logic [7:0] rd_val;
  always_comb begin
    case (idx)
      `DSC_PTR_CMD: rd_val = ch ? primary_status_b_in : primary_status_a_in;
      `DSC_PTR_SRX: rd_val = {1'b0, crc_err_r[ch], 6'h00};
      `DSC_PTR_VEC: rd_val = ch ? vec_mod : int_vector_r;
      `DSC_PTR_RXP: rd_val = ch ? 8'h00 : {2'b00, ip};
      `DSC_PTR_MMODE: rd_val = rb_en ? wr4_r[ch] : 8'h00;
      `DSC_PTR_TXP: rd_val = rb_en ? wr5_r[ch] : 8'h00;
      `DSC_PTR_FCNT_LO: rd_val = fifo_en ? fhead[7:0] : 8'h00;
      `DSC_PTR_SYNC: rd_val = fifo_en ? {fovf_r[ch], fvalid, fhead[13:8]} : 8'h00;
      `DSC_PTR_DATA: rd_val = ch ? rx_data_b_in : rx_data_a_in;
      `DSC_PTR_MIC: rd_val = rb_en ? wr3_r[ch] : 8'h00;
      `DSC_PTR_RB_MCTL: rd_val = rb_en ? misc_ctrl_write_reg_r[ch] : 8'h00;
      `DSC_PTR_RB_SYNC: rd_val = rb_en ? wr7_r[ch] : 8'h00;
      `DSC_PTR_ESC: rd_val = ext_status_ctrl_write_reg_r[ch];
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------
  // host port: read data, data strobes, shared registers
  // ----------------------------------------
  // read data is held until the next read so the core may sample late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io_rdata_r <= `DSC_REG_RST;
      tx_data_r <= `DSC_REG_RST;
      tx_load_r <= 2'b00;
      rx_take_r <= 2'b00;
      int_vector_r <= `DSC_REG_RST;
      master_int_ctrl_r <= `DSC_REG_RST;
    end else begin
      if (rd) begin
        io_rdata_r <= rd_val;
      end
      if (reg_wr & (idx == `DSC_PTR_DATA)) begin
        tx_data_r <= io_wdata;
      end
      tx_load_r <= {reg_wr & ch, reg_wr & ~ch} & {2{idx == `DSC_PTR_DATA}};
      rx_take_r <= {rd & ch, rd & ~ch} & {2{idx == `DSC_PTR_DATA}};
      if (reg_wr & (idx == `DSC_PTR_VEC)) begin
        int_vector_r <= io_wdata;
      end
      if (mic_wr) begin
        master_int_ctrl_r <= io_wdata;
      end
    end
  end

  // ----------------------------------------
  // per-channel pointer and write registers
  // ----------------------------------------
  genvar g;
  for (g = 0; g < 2; g++) begin : g_ch
    wire sel = (ch == 1'(g));
    wire wr_here = reg_wr & sel;
    // pointer: set by command write, cleared once the second access is done
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        ptr_r[g] <= `DSC_PTR_CMD;
      end else if (cmd_wr & sel) begin
        ptr_r[g] <= cmd_ptr;
      end else if ((ctrl_done & sel) | ch_rst[g]) begin
        ptr_r[g] <= `DSC_PTR_CMD;
      end
    end

    // extended feature write is steered by the enable bit of status control
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        wr3_r[g] <= `DSC_REG_RST;
        wr4_r[g] <= `DSC_REG_RST;
        wr5_r[g] <= `DSC_REG_RST;
        wr7_r[g] <= `DSC_REG_RST;
        wr7p_r[g] <= `DSC_REG_RST;
        misc_ctrl_write_reg_r[g] <= `DSC_REG_RST;
        ext_status_ctrl_write_reg_r[g] <= `DSC_REG_RST;
      end else if (ch_rst[g]) begin
        wr7p_r[g] <= `DSC_REG_RST;
        ext_status_ctrl_write_reg_r[g] <= `DSC_REG_RST;
      end else if (wr_here) begin
        case (idx)
          `DSC_PTR_RXP: wr3_r[g] <= io_wdata;
          `DSC_PTR_MMODE: wr4_r[g] <= io_wdata;
          `DSC_PTR_TXP: wr5_r[g] <= io_wdata;
          `DSC_PTR_SYNC: begin
            if (ext_sel) begin
              wr7p_r[g] <= io_wdata;
            end else begin
              wr7_r[g] <= io_wdata;
            end
          end
          `DSC_PTR_MCTL: misc_ctrl_write_reg_r[g] <= io_wdata;
          `DSC_PTR_ESC: ext_status_ctrl_write_reg_r[g] <= io_wdata;
          default: ext_status_ctrl_write_reg_r[g] <= ext_status_ctrl_write_reg_r[g];
        endcase
      end
    end

    // crc engine: the selected width is the only one that runs
    wire w32 = wr7p_r[g][`DSC_EXT_CRC32_BIT];
    wire pre1 = misc_ctrl_write_reg_r[g][`DSC_MCTL_PRESET_BIT];
    wire [31:0] preset = w32 ? {32{pre1}} : {16'h0000, {16{pre1}}};
    wire [31:0] residue = pre1 ? (w32 ? `DSC_RES32 : {16'h0000, `DSC_RES16}) : 32'h0000_0000;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        crc_r[g] <= 32'h0000_0000;
        crc_err_r[g] <= 1'b0;
        bcnt_r[g] <= 14'h0000;
      end else begin
        if (crc_preset_in[g]) begin
          crc_r[g] <= preset;
        end else if (crc_bit_valid_in[g]) begin
          crc_r[g] <= crc_step(crc_r[g], crc_bit_in[g], w32);
        end else if (!w32) begin
          // a 32-bit run may leave the upper half set; drop it once 16-bit is chosen
          crc_r[g] <= {16'h0000, crc_r[g][15:0]};
        end
        if (frame_end_in[g]) begin
          crc_err_r[g] <= (crc_r[g] != residue);
        end
        if (crc_preset_in[g]) begin
          bcnt_r[g] <= 14'h0000;
        end else if (rx_byte_in[g]) begin
          bcnt_r[g] <= bcnt_r[g] + 14'h0001;
        end
      end
    end

    // frame status fifo; a push always beats the overflow clear
    wire push = frame_end_in[g] & ext_status_ctrl_write_reg_r[g][`DSC_ESC_FIFO_EN_BIT];
    wire full = (fcnt_r[g] == PW'(FIFO_DEPTH));
    wire pop = rd & sel & ~is_data & (cur_ptr == `DSC_PTR_SYNC) & fifo_en & fvalid;
    wire do_push = push & ~full;
    wire [18:0] entry = {crc_r[g] != residue, w32, 3'b000, bcnt_r[g]};
    always_ff @(posedge core_clk) begin
      if (do_push) begin
        fifo_mem[g][fwp_r[g]] <= entry;
      end
    end
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        fwp_r[g] <= '0;
        frp_r[g] <= '0;
        fcnt_r[g] <= '0;
        fovf_r[g] <= 1'b0;
      end else begin
        if (do_push) begin
          fwp_r[g] <= ptr_inc(fwp_r[g]);
        end
        if (pop) begin
          frp_r[g] <= ptr_inc(frp_r[g]);
        end
        fcnt_r[g] <= fcnt_r[g] + PW'(do_push) - PW'(pop);
        if (push & full) begin
          fovf_r[g] <= 1'b1;
        end else if (~ext_status_ctrl_write_reg_r[g][`DSC_ESC_FIFO_EN_BIT]) begin
          fovf_r[g] <= 1'b0;
        end
      end
    end
  end

  assign tx_crc_a_r = crc_r[0];
  assign tx_crc_b_r = crc_r[1];
  assign crc_mode32_r = {wr7p_r[1][`DSC_EXT_CRC32_BIT], wr7p_r[0][`DSC_EXT_CRC32_BIT]};

  // ----------------------------------------
  // core clock divider and channel B borrowing
  // ----------------------------------------
  // enable toggles in divide-by-2, stays high in divide-by-1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scc_clk_en_r <= 1'b1;
      chb_pin_out_r <= 4'h0;
      chb_pin_oe_r <= 4'h0;
      emu_timer_clk_r <= 1'b0;
    end else begin
      scc_clk_en_r <= clk_div2_in ? ~scc_clk_en_r : 1'b1;
      chb_pin_out_r <= emu_enable_in ? 4'h0 : chb_core_out_in;
      chb_pin_oe_r <= emu_enable_in ? 4'h0 : chb_core_oe_in;
      emu_timer_clk_r <= emu_enable_in & chan_b_txrx_clock_pin;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PAGE: assert property (@(posedge core_clk) disable iff (rst)
    io_wr && io_addr[7:0] == `DSC_ADDR_CHA_DATA && io_addr[15:8] != 8'h00 |=> tx_load_r[0])
    else $error("data port missed in a high page");
  AST_MAP_B: assert property (@(posedge core_clk) disable iff (rst)
    io_rd && io_addr[7:0] == `DSC_ADDR_CHB_DATA |=> rx_take_r == 2'b10)
    else $error("channel B data port not mapped");
  AST_EMU_OFF: assert property (@(posedge core_clk) disable iff (rst)
    emu_enable_in ##1 emu_enable_in |-> chb_pin_oe_r == 4'h0 && chb_pin_out_r == 4'h0)
    else $error("channel B still drives its pins");
  AST_EMU_CLK: assert property (@(posedge core_clk) disable iff (rst)
    emu_enable_in |=> emu_timer_clk_r == $past(chan_b_txrx_clock_pin))
    else $error("emulation timer clock not routed");
  AST_DIRECT: assert property (@(posedge core_clk) disable iff (rst)
    io_wr && io_addr[7:0] == `DSC_ADDR_CHA_DATA |=> tx_data_r == $past(io_wdata) && ptr_r[0] == $past(ptr_r[0]))
    else $error("direct data write wrong");
  AST_CMD: assert property (@(posedge core_clk) disable iff (rst)
    io_wr && io_addr[7:0] == `DSC_ADDR_CHA_CTRL && ptr_r[0] == `DSC_PTR_CMD
    |=> ptr_r[0][2:0] == $past(io_wdata[2:0]))
    else $error("pointer not taken from command write");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    (io_wr || io_rd) && io_addr[7:0] == `DSC_ADDR_CHB_CTRL && ptr_r[1] != `DSC_PTR_CMD
    |=> ptr_r[1] == `DSC_PTR_CMD)
    else $error("pointer not cleared");
  AST_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
    !crc_mode32_r[0] ##1 !crc_mode32_r[0] |-> tx_crc_a_r[31:16] == 16'h0000)
    else $error("16-bit crc ran with upper half");
  AST_EXT_GATE: assert property (@(posedge core_clk) disable iff (rst)
    io_wr && io_addr[7:0] == `DSC_ADDR_CHA_CTRL && ptr_r[0] == `DSC_PTR_SYNC
    && !ext_status_ctrl_write_reg_r[0][`DSC_ESC_EXT_EN_BIT] |=> $stable(crc_mode32_r))
    else $error("extended register written while gated");
  AST_IP_A: assert property (@(posedge core_clk) disable iff (rst)
    io_rd && io_addr[7:0] == `DSC_ADDR_CHB_CTRL && ptr_r[1] == `DSC_PTR_RXP |=> io_rdata_r == 8'h00)
    else $error("pending bits visible on channel B");
  AST_FIFO_GATE: assert property (@(posedge core_clk) disable iff (rst)
    io_rd && io_addr[7:0] == `DSC_ADDR_CHA_CTRL && ptr_r[0] == `DSC_PTR_FCNT_LO
    && !ext_status_ctrl_write_reg_r[0][`DSC_ESC_FIFO_EN_BIT] |=> io_rdata_r == 8'h00)
    else $error("byte count readable while disabled");
  AST_DIV1: assert property (@(posedge core_clk) disable iff (rst)
    !clk_div2_in |=> scc_clk_en_r)
    else $error("divide-by-1 did not enable every cycle");
endmodule

// >>> src/dsc_pkg.sv
package dsc_pkg;
  // shared interrupt register reset command field
  typedef enum logic [1:0] {DSC_RST_NONE, DSC_RST_CHB, DSC_RST_CHA, DSC_RST_HW} dsc_rst_cmd_t;
  typedef logic [18:0] dsc_fifo_entry_t;
endpackage

// >>> verif/dsc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// processor core model on the internal io bus
// ----------------------------------------
module dsc_host_model (
  input wire logic core_clk,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd,
  input wire logic [7:0] io_rdata_r
);
  // idle bus at time zero, no strobe before reset is released
  initial begin
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end

  // one-cycle write strobe; data is scrambled once released so stale data never looks valid
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
    #1;
  endtask

  // one-cycle read strobe; answer is registered at the edge that takes the strobe
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1;
    d = io_rdata_r;
  endtask

  // indirect accesses always lead with the pointer write
  task automatic reg_wr(input logic [15:0] ctl, input logic [7:0] ptr, input logic [7:0] d);
    bus_wr(ctl, ptr);
    bus_wr(ctl, d);
  endtask

  task automatic reg_rd(input logic [15:0] ctl, input logic [7:0] ptr, output logic [7:0] d);
    bus_wr(ctl, ptr);
    bus_rd(ctl, d);
  endtask
endmodule

// >>> verif/tb_dual_serial_ctrl_host_access_crc32.sv
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module tb_dual_serial_ctrl_host_access_crc32;
  // control ports placed in different io pages on purpose
  localparam logic [15:0] CA = {8'h3C, `DSC_ADDR_CHA_CTRL};
  localparam logic [15:0] CB = {8'hC3, `DSC_ADDR_CHB_CTRL};
  localparam logic [7:0] STA = 8'h91;
  localparam logic [7:0] STB = 8'h26;
  localparam logic [7:0] RXA = 8'h4D;
  localparam logic [7:0] RXB = 8'hB2;
  logic core_clk, rst, io_wr, io_rd, clk_div2_in, emu_enable_in, chan_b_txrx_clock_pin;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata_r, tx_data_r, int_vector_r, master_int_ctrl_r;
  logic [5:0] interrupt_pending_bits;
  logic [1:0] crc_preset_in, crc_bit_valid_in, crc_bit_in, rx_byte_in, frame_end_in;
  logic [1:0] tx_load_r, rx_take_r, crc_mode32_r;
  logic [3:0] chb_core_out_in, chb_core_oe_in, chb_pin_out_r, chb_pin_oe_r;
  logic [31:0] tx_crc_a_r, tx_crc_b_r;
  logic scc_clk_en_r, emu_timer_clk_r;
  int errors = 0;
  int checked = 0;

  dsc_host_model HOST (.core_clk, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata_r);
  dsc_host_access #(.FIFO_DEPTH(10)) DUT (.core_clk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata_r,
    .primary_status_a_in(STA), .primary_status_b_in(STB), .rx_data_a_in(RXA), .rx_data_b_in(RXB),
    .interrupt_pending_bits, .crc_preset_in, .crc_bit_valid_in, .crc_bit_in, .rx_byte_in, .frame_end_in,
    .clk_div2_in, .emu_enable_in, .chan_b_txrx_clock_pin, .chb_core_out_in, .chb_core_oe_in, .tx_data_r,
    .tx_load_r, .rx_take_r, .crc_mode32_r, .tx_crc_a_r, .tx_crc_b_r, .int_vector_r, .master_int_ctrl_r,
    .scc_clk_en_r, .chb_pin_out_r, .chb_pin_oe_r, .emu_timer_clk_r);

  // ----------------------------------------
  // clocks and watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // channel b clock runs as an output baud clock, offset so it never meets a core edge
  initial begin
    chan_b_txrx_clock_pin = 1'b0;
    #5;
    forever #110 chan_b_txrx_clock_pin = ~chan_b_txrx_clock_pin;
  end
  // tests take about 150 cycles; the limit of 10000 cycles leaves wide margin
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one-cycle pulse on the per-channel crc and frame strobes
  task automatic pulse(input logic [1:0] pre, input logic [1:0] val, input logic [1:0] rb, input logic [1:0] fe);
    @(posedge core_clk);
    crc_preset_in <= pre;
    crc_bit_valid_in <= val;
    rx_byte_in <= rb;
    frame_end_in <= fe;
    @(posedge core_clk);
    {crc_preset_in, crc_bit_valid_in, rx_byte_in, frame_end_in} <= 8'h00;
    #1;
  endtask

  // reset checks outputs while held, then the first control read must land on status
  task automatic do_reset;
    logic [7:0] d;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(crc_mode32_r, 2'b00, "crc32 mode in reset");
    chk(scc_clk_en_r, 1'b1, "divide by one in reset");
    rst <= 1'b0;
    HOST.bus_rd(CA, d);
    chk(d, STA, "first control read");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_data;
    logic [7:0] d;
    HOST.bus_wr({8'h5A, `DSC_ADDR_CHA_DATA}, 8'h3C);
    #1;
    chk({tx_load_r, tx_data_r}, {2'b01, 8'h3C}, "data a write");
    HOST.bus_wr({8'hFF, `DSC_ADDR_CHB_DATA}, 8'hC5);
    #1;
    chk({tx_load_r, tx_data_r}, {2'b10, 8'hC5}, "data b write");
    HOST.bus_wr(16'h00E4, 8'h77);
    #1;
    chk({tx_load_r, tx_data_r}, {2'b00, 8'hC5}, "unmapped write");
    HOST.bus_rd({8'h12, `DSC_ADDR_CHB_DATA}, d);
    chk({rx_take_r, d}, {2'b10, RXB}, "data b read");
    HOST.bus_rd(CB, d);
    chk(d, STB, "status b");
  endtask

  task automatic t_pointer_ext;
    logic [7:0] d;
    HOST.reg_wr(CA, 8'h03, 8'h5C);
    HOST.reg_wr(CA, 8'h04, 8'hA5);
    HOST.reg_rd(CA, 8'h09, d);
    chk(d, 8'h00, "readback gated");
    HOST.reg_wr(CA, 8'h07, 8'h80);
    chk(crc_mode32_r, 2'b00, "ext write refused");
    HOST.reg_wr(CA, 8'h0F, 8'h05);
    HOST.reg_wr(CA, 8'h07, 8'hC0);
    chk(crc_mode32_r, 2'b01, "crc32 selected");
    HOST.reg_rd(CA, 8'h0E, d);
    chk(d, 8'h80, "sync readback");
    HOST.reg_rd(CA, 8'h09, d);
    chk(d, 8'h5C, "rx params readback");
    HOST.reg_rd(CA, 8'h04, d);
    chk(d, 8'hA5, "mode read");
    HOST.bus_rd(CA, d);
    chk(d, STA, "pointer cleared");
  endtask

  // a single one bit from a zero preset leaves exactly the polynomial in the register
  task automatic t_crc_fifo;
    logic [7:0] d;
    crc_bit_in <= 2'b11;
    pulse(2'b11, 2'b00, 2'b00, 2'b00);
    chk({tx_crc_a_r, tx_crc_b_r}, 64'h0, "zero preset");
    pulse(2'b00, 2'b11, 2'b00, 2'b00);
    chk(tx_crc_a_r, `DSC_POLY32, "crc32 step");
    chk(tx_crc_b_r, {16'h0000, `DSC_POLY16}, "crc16 step");
    repeat (3) pulse(2'b00, 2'b00, 2'b01, 2'b00);
    pulse(2'b00, 2'b00, 2'b00, 2'b11);
    HOST.reg_rd(CA, 8'h01, d);
    chk(d, 8'h40, "crc32 error flag");
    pulse(2'b01, 2'b00, 2'b00, 2'b00);
    pulse(2'b00, 2'b00, 2'b00, 2'b01);
    HOST.reg_rd(CA, 8'h01, d);
    chk(d, 8'h00, "crc32 good flag");
    HOST.reg_rd(CA, 8'h06, d);
    chk(d, 8'h03, "fifo byte count");
    HOST.reg_wr(CA, 8'h0F, 8'h01);
    HOST.reg_rd(CA, 8'h06, d);
    chk(d, 8'h00, "fifo count gated");
    HOST.reg_wr(CA, 8'h0A, 8'h80);
    pulse(2'b01, 2'b00, 2'b00, 2'b00);
    chk(tx_crc_a_r, 32'hFFFFFFFF, "ones preset");
  endtask

  task automatic t_shared;
    logic [7:0] d;
    HOST.reg_wr(CB, 8'h02, 8'h5A);
    chk(int_vector_r, 8'h5A, "vector via b");
    HOST.reg_rd(CA, 8'h02, d);
    chk(d, 8'h5A, "vector read a");
    HOST.reg_wr(CB, 8'h09, 8'h04);
    chk(master_int_ctrl_r, 8'h04, "master int via b");
    interrupt_pending_bits <= 6'h2A;
    HOST.reg_rd(CA, 8'h03, d);
    chk(d, 8'h2A, "pending via a");
    HOST.reg_rd(CB, 8'h03, d);
    chk(d, 8'h00, "pending via b");
    HOST.reg_rd(CB, 8'h02, d);
    chk(d, 8'h5C, "vector read b");
    HOST.reg_wr(CA, 8'h09, 8'h40);
    chk({master_int_ctrl_r, crc_mode32_r}, {8'h40, 2'b01}, "channel b reset spares a");
  endtask

  task automatic t_clk_emu;
    logic prev;
    @(posedge core_clk);
    clk_div2_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    prev = scc_clk_en_r;
    repeat (4) begin
      @(posedge core_clk);
      #1;
      chk(scc_clk_en_r ^ prev, 1'b1, "divide by two");
      prev = scc_clk_en_r;
    end
    clk_div2_in <= 1'b0;
    emu_enable_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    repeat (12) begin
      @(posedge core_clk);
      #1;
      chk(scc_clk_en_r, 1'b1, "divide by one");
      chk({chb_pin_out_r, chb_pin_oe_r}, 8'h00, "b pins cut off");
      chk(emu_timer_clk_r, chan_b_txrx_clock_pin, "timer clock");
    end
    emu_enable_in <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({chb_pin_out_r, chb_pin_oe_r, emu_timer_clk_r}, {8'h96, 1'b0}, "b pins back");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {crc_preset_in, crc_bit_valid_in, crc_bit_in, rx_byte_in, frame_end_in} = 10'h000;
    interrupt_pending_bits = 6'h00;
    clk_div2_in = 1'b0;
    emu_enable_in = 1'b0;
    chb_core_out_in = 4'h9;
    chb_core_oe_in = 4'h6;
    do_reset();
    t_data();
    t_pointer_ext();
    t_crc_fifo();
    t_shared();
    t_clk_emu();
    HOST.bus_wr(CA, 8'h05);
    do_reset();
    tally_and_finish();
  end

  task automatic tally_and_finish;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
endmodule
